// *** core/dps_map.vh ***
// Register map, codes and timing constants of the diagnostic panel sequencer.
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

`define DPS_CLK_HZ 25000000
`define DPS_CYC_PER_MS (`DPS_CLK_HZ / 1000)

`define DPS_OFS_CTRL 8'h00
`define DPS_OFS_STATUS 8'h04
`define DPS_OFS_CRC 8'h08
`define DPS_OFS_DISP 8'h0c
`define DPS_CTRL_INIT_BIT 0
`define DPS_CTRL_HALT_BIT 1
`define DPS_CTRL_RESET 2'h0

`define DPS_MODE_NORMAL 3'h0
`define DPS_MODE_CTRL 3'h3
`define DPS_MODE_ALIGN 3'h4
`define DPS_MODE_RW 3'h5

`define DPS_OP_ALU 4'h0
`define DPS_OP_RAM 4'h1
`define DPS_OP_CRC 4'h2
`define DPS_OP_PLL 4'h3
`define DPS_OP_SEEK 4'h4
`define DPS_OP_LOAD 4'h5
`define DPS_OP_UNLOAD 4'h6
`define DPS_OP_SCAN 4'h7
`define DPS_OP_SEQWR 4'h8
`define DPS_OP_RDHDR 4'h9

`define DPS_ERR_NONE 9'h000
`define DPS_ERR_HOME 9'h008
`define DPS_ERR_NODRV 9'h010
`define DPS_ERR_TRK00 9'h018
`define DPS_ERR_WPROT 9'h040
`define DPS_ERR_HDRCRC 9'h060
`define DPS_ERR_HDRTRK 9'h068
`define DPS_ERR_DATCRC 9'h080
`define DPS_ERR_CLASS 9'h110

`define DPS_CRC_LIMIT 5'h10
`define DPS_SEEK_MS 8'h64
`define DPS_LOAD_MS 8'h64
`define DPS_UNLOAD_MS 8'hc8
`define DPS_LAMP_MS 8'hfa
`define DPS_FLASH_MS 8'hfa
`define DPS_TRK_38 10'h026
`define DPS_TRK_76 10'h04c

`endif

// *** core/dps_ms_timer.v ***
// Millisecond prescaler and one-shot millisecond countdown.
`timescale 1ns/1ps
`default_nettype none
module dps_ms_timer #(
	parameter CYC_PER_MS = 25000
) (
	input wire hclk,
	input wire hresetn,
	input wire start,
	input wire [7:0] ms_val,
	output reg ms_tick,
	output reg done
);
	reg [31:0] pre_reg;
	reg [7:0] cnt_reg;
	reg run_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_reg <= 32'h0;
			ms_tick <= 1'b0;
			cnt_reg <= 8'h0;
			run_reg <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			ms_tick <= 1'b0;
			// Restarting the prescaler makes a delay exact rather than one ms short.
			if (start || pre_reg == CYC_PER_MS - 1)
				pre_reg <= 32'h0;
			else
				pre_reg <= pre_reg + 32'h1;
			if (!start && pre_reg == CYC_PER_MS - 1)
				ms_tick <= 1'b1;
			if (start) begin
				cnt_reg <= ms_val;
				run_reg <= 1'b1;
			end else if (run_reg && pre_reg == CYC_PER_MS - 1) begin
				if (cnt_reg == 8'h1) begin
					run_reg <= 1'b0;
					done <= 1'b1;
				end
				cnt_reg <= cnt_reg - 8'h1;
			end
		end
	end
endmodule // dps_ms_timer
`default_nettype wire

// *** core/dps_sequencer.v ***
// Front-panel diagnostic sequencer with an AHB-Lite register slave.
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dps_map.vh"
// Notes on behaviour
// - Mode 3 plus execute enters controller tests; class picks the routine.
// - Lamp test, floppy lock on: floppy lock and fault lamps, flash 88.
// - Lamp test, fixed lock on: fixed lock and fault lamps, flash 99.
// - No lock on: five lamps lit one at a time in turn.
// - During lamp sequencing the digits echo class and mode switches.
// - Class 1 runs ALU, RAM, CRC, PLL in order; classes 2-5 one each.
// - Class 6 shows the microcode version on the digits.
// - Align class 0 loads head, seeks 00/01 alternately every 100 ms forever.
// - Align classes 1-4 seek track 01, 02, 38 or 76, then load head.
// - Align class 5 seeks 00, then loads 100 ms and unloads 200 ms forever.
// - Read/write class 0 scans the floppy once without writing.
// - Floppy butterfly seek, then track 00; no media needed; repeats.
// - Floppy butterfly header test flags header track mismatch.
// - Fixed butterfly seek, then seek cylinder 00 and verify; repeats.
// - Fixed write/read test refused unless class 7 ran first.
// - Displayed code is the octal host code without its last digit.
// - Error shows code, lights summary fault and the drive's fault lamp.
// - In normal mode any error ends the operation and is reported.
// - Diagnostic CRC errors 14 and 20 are totalled and retried.
// - Routine ends when the CRC total reaches 16.
// - Digits blank until initialisation completes, except during lamp test, error or show; 00 means no fault.
// - Codes 01 home fail, 02 no drive, 03 track 00 inward.
// - Execute during a routine stops it.
module dps_sequencer #(
	parameter CYC_PER_MS = `DPS_CYC_PER_MS,
	parameter [9:0] FLP_MAX_TRK = `DPS_TRK_76,
	parameter [9:0] FIX_MAX_CYL = 10'h131,
	parameter [7:0] UCODE_VERSION = 8'h12 // Arbitrary value.
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [2:0] mode_sw,
	input wire [2:0] class_sw,
	input wire exec_btn,
	input wire flp_lock_sw,
	input wire fix_lock_sw,
	input wire init_home_fail,
	input wire init_no_drive,
	input wire init_trk00_in,
	input wire norm_err,
	input wire [8:0] norm_err_code,
	input wire err_drive,
	input wire op_done,
	input wire [8:0] op_err,
	input wire [9:0] op_hdr_trk,
	output reg op_req,
	output reg [3:0] op_code,
	output reg op_drive,
	output reg [9:0] op_track,
	output reg op_abort,
	output reg [3:0] dig_hi,
	output reg [3:0] dig_lo,
	output reg dig_blank,
	output reg lamp_flp_lock,
	output reg lamp_flp_fault,
	output reg lamp_fix_lock,
	output reg lamp_fix_fault,
	output reg lamp_sum_fault,
	output reg lamp_fix_ready
);
	localparam S_IDLE = 3'h0;
	localparam S_LAMP = 3'h1;
	localparam S_ISSUE = 3'h2;
	localparam S_WAIT = 3'h3;
	localparam S_DELAY = 3'h4;
	localparam S_SHOW = 3'h5;
	localparam S_ERR = 3'h6;

	reg [2:0] state_reg;
	reg [1:0] step_reg;
	reg [9:0] bf_reg;
	reg [4:0] crc_reg;
	reg [8:0] code_reg;
	reg code_drv_reg;
	reg wen_reg;
	reg exec_d_reg;
	reg init_reg;
	reg flash_reg;
	reg [7:0] fl_cnt_reg;
	reg [2:0] lamp_idx_reg;
	reg [7:0] lamp_cnt_reg;
	reg [7:0] show_reg;
	reg [2:0] run_mode_reg;
	reg [2:0] run_class_reg;
	reg tm_start_reg;
	reg [7:0] tm_ms_reg;
	reg halt_reg;
	reg [3:0] a_ofs_reg;
	reg a_wr_reg;
	reg a_ok_reg;

	wire ms_tick;
	wire tm_done;
	wire press = exec_btn & ~exec_d_reg;
	wire stop = press | halt_reg;

	dps_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(tm_start_reg),
		.ms_val(tm_ms_reg),
		.ms_tick(ms_tick),
		.done(tm_done)
	);

	// Step table: what the current step of the running routine does.
	reg [3:0] t_op;
	reg t_drv;
	reg [9:0] t_trk;
	reg [7:0] t_ms;
	reg [1:0] t_end;
	reg [1:0] t_loop;
	reg [1:0] t_kind;
	reg t_bf;
	reg t_chk;
	always @* begin
		t_op = `DPS_OP_SEEK;
		t_drv = 1'b0;
		t_trk = 10'h0;
		t_ms = 8'h0;
		t_end = 2'h1;
		t_loop = 2'h0;
		t_kind = 2'h1;
		t_bf = 1'b0;
		t_chk = 1'b0;
		case (run_mode_reg)
		`DPS_MODE_CTRL: begin
			if (run_class_reg == 3'h1) begin
				t_kind = 2'h0;
				t_op = {2'h0, step_reg};
				t_end = (step_reg == 2'h3) ? 2'h1 : 2'h0;
			end else if (run_class_reg >= 3'h2 && run_class_reg <= 3'h5) begin
				t_kind = 2'h0;
				t_op = {1'b0, run_class_reg} - 4'h2;
			end else if (run_class_reg == 3'h6) begin
				t_kind = 2'h2;
			end
		end
		`DPS_MODE_ALIGN: begin
			t_kind = 2'h0;
			case (run_class_reg)
			3'h0: begin
				t_op = (step_reg == 2'h0) ? `DPS_OP_LOAD : `DPS_OP_SEEK;
				t_trk = (step_reg == 2'h1) ? 10'h1 : 10'h0;
				t_ms = (step_reg == 2'h0) ? 8'h0 : `DPS_SEEK_MS;
				t_end = (step_reg == 2'h2) ? 2'h2 : 2'h0;
				t_loop = 2'h1;
			end
			3'h1, 3'h2, 3'h3, 3'h4: begin
				t_op = (step_reg == 2'h0) ? `DPS_OP_SEEK : `DPS_OP_LOAD;
				t_end = (step_reg == 2'h0) ? 2'h0 : 2'h1;
				case (run_class_reg)
				3'h1: t_trk = 10'h1;
				3'h2: t_trk = 10'h2;
				3'h3: t_trk = `DPS_TRK_38;
				default: t_trk = `DPS_TRK_76;
				endcase
			end
			3'h5: begin
				case (step_reg)
				2'h0: t_op = `DPS_OP_SEEK;
				2'h1: t_op = `DPS_OP_LOAD;
				default: t_op = `DPS_OP_UNLOAD;
				endcase
				t_ms = (step_reg == 2'h1) ? `DPS_LOAD_MS :
					(step_reg == 2'h2) ? `DPS_UNLOAD_MS : 8'h0;
				t_end = (step_reg == 2'h2) ? 2'h2 : 2'h0;
				t_loop = 2'h1;
			end
			default: t_kind = 2'h1;
			endcase
		end
		`DPS_MODE_RW: begin
			t_kind = 2'h0;
			t_end = 2'h2;
			case (run_class_reg)
			3'h0: begin
				t_op = `DPS_OP_SCAN;
				t_end = 2'h1;
			end
			3'h1, 3'h5: begin
				t_drv = run_class_reg[2];
				t_bf = (step_reg == 2'h0);
				t_chk = run_class_reg[2] && step_reg == 2'h1;
				t_op = (t_chk) ? `DPS_OP_RDHDR : `DPS_OP_SEEK;
				t_end = (step_reg == 2'h0) ? 2'h0 : 2'h2;
			end
			3'h2: begin
				t_op = `DPS_OP_RDHDR;
				t_bf = 1'b1;
				t_chk = 1'b1;
			end
			3'h3: t_op = `DPS_OP_SEQWR;
			3'h4: begin
				t_op = `DPS_OP_SCAN;
				t_drv = 1'b1;
			end
			3'h6: begin
				t_op = `DPS_OP_SEQWR;
				t_drv = 1'b1;
			end
			default: t_kind = 2'h3;
			endcase
		end
		default: t_kind = 2'h1;
		endcase
	end

	wire [9:0] bf_max = t_drv ? FIX_MAX_CYL : FLP_MAX_TRK;
	wire [9:0] bf_half = {1'b0, bf_reg[9:1]};
	wire [9:0] bf_trk = bf_reg[0] ? bf_max - bf_half : bf_half;
	wire is_crc = (op_err == `DPS_ERR_HDRCRC) || (op_err == `DPS_ERR_DATCRC);
	wire [4:0] crc_inc = crc_reg + 5'h1;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
			step_reg <= 2'h0;
			bf_reg <= 10'h0;
			crc_reg <= 5'h0;
			code_reg <= `DPS_ERR_NONE;
			code_drv_reg <= 1'b0;
			wen_reg <= 1'b0;
			exec_d_reg <= 1'b0;
			show_reg <= 8'h0;
			run_mode_reg <= 3'h0;
			run_class_reg <= 3'h0;
			tm_start_reg <= 1'b0;
			tm_ms_reg <= 8'h0;
			op_req <= 1'b0;
			op_code <= 4'h0;
			op_drive <= 1'b0;
			op_track <= 10'h0;
			op_abort <= 1'b0;
		end else begin
			exec_d_reg <= exec_btn;
			op_req <= 1'b0;
			op_abort <= 1'b0;
			tm_start_reg <= 1'b0;
			if (wen_reg && mode_sw != `DPS_MODE_RW)
				wen_reg <= 1'b0;
			case (state_reg)
			S_IDLE, S_SHOW, S_ERR: begin
				if (init_home_fail | init_no_drive | init_trk00_in) begin
					state_reg <= S_ERR;
					code_drv_reg <= err_drive;
					code_reg <= init_home_fail ? `DPS_ERR_HOME :
						init_no_drive ? `DPS_ERR_NODRV : `DPS_ERR_TRK00;
				end else if (norm_err && mode_sw == `DPS_MODE_NORMAL) begin
					state_reg <= S_ERR;
					op_abort <= 1'b1;
					code_reg <= norm_err_code;
					code_drv_reg <= err_drive;
				end else if (press && mode_sw != `DPS_MODE_NORMAL) begin
					run_mode_reg <= mode_sw;
					run_class_reg <= class_sw;
					step_reg <= 2'h0;
					bf_reg <= 10'h0;
					crc_reg <= 5'h0;
					code_reg <= `DPS_ERR_NONE;
					show_reg <= 8'h0;
					if (mode_sw == `DPS_MODE_CTRL && class_sw == 3'h0)
						state_reg <= S_LAMP;
					else
						state_reg <= S_ISSUE;
				end
			end
			S_LAMP: if (stop) state_reg <= S_IDLE;
			S_ISSUE: begin
				if (stop) begin
					state_reg <= S_IDLE;
				end else if (t_kind == 2'h1) begin
					state_reg <= S_ERR;
					code_reg <= `DPS_ERR_CLASS;
				end else if (t_kind == 2'h2) begin
					show_reg <= UCODE_VERSION;
					state_reg <= S_SHOW;
				end else if (t_kind == 2'h3) begin
					wen_reg <= 1'b1;
					state_reg <= S_SHOW;
				end else if (t_op == `DPS_OP_SEQWR && t_drv && !wen_reg) begin
					state_reg <= S_ERR;
					code_reg <= `DPS_ERR_WPROT;
					code_drv_reg <= 1'b1;
				end else begin
					op_req <= 1'b1;
					op_code <= t_op;
					op_drive <= t_drv;
					op_track <= t_bf ? bf_trk : t_trk;
					state_reg <= S_WAIT;
				end
			end
			S_WAIT: begin
				if (stop) begin
					op_abort <= 1'b1;
					state_reg <= S_IDLE;
				end else if (op_done) begin
					code_drv_reg <= op_drive;
					if (op_err != `DPS_ERR_NONE && is_crc) begin
						crc_reg <= crc_inc;
						code_reg <= op_err;
						state_reg <= (crc_inc == `DPS_CRC_LIMIT) ? S_ERR : S_ISSUE;
					end else if (op_err != `DPS_ERR_NONE) begin
						code_reg <= op_err;
						state_reg <= S_ERR;
					end else if (t_chk && op_hdr_trk != op_track) begin
						code_reg <= `DPS_ERR_HDRTRK;
						state_reg <= S_ERR;
					end else if (t_bf && bf_reg != bf_max) begin
						bf_reg <= bf_reg + 10'h1;
						state_reg <= S_ISSUE;
					end else if (t_ms != 8'h0) begin
						tm_start_reg <= 1'b1;
						tm_ms_reg <= t_ms;
						state_reg <= S_DELAY;
					end else begin
						bf_reg <= 10'h0;
						step_reg <= (t_end == 2'h2) ? t_loop : step_reg + 2'h1;
						state_reg <= (t_end == 2'h1) ? S_SHOW : S_ISSUE;
					end
				end
			end
			S_DELAY: begin
				if (stop) begin
					state_reg <= S_IDLE;
				end else if (tm_done) begin
					step_reg <= (t_end == 2'h2) ? t_loop : step_reg + 2'h1;
					state_reg <= (t_end == 2'h1) ? S_SHOW : S_ISSUE;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Panel lamps, digits, flash and lamp stepping.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_reg <= 1'b0;
			fl_cnt_reg <= 8'h0;
			lamp_idx_reg <= 3'h0;
			lamp_cnt_reg <= 8'h0;
			dig_hi <= 4'h0;
			dig_lo <= 4'h0;
			dig_blank <= 1'b1;
			lamp_flp_lock <= 1'b0;
			lamp_flp_fault <= 1'b0;
			lamp_fix_lock <= 1'b0;
			lamp_fix_fault <= 1'b0;
			lamp_sum_fault <= 1'b0;
			lamp_fix_ready <= 1'b0;
		end else begin
			if (ms_tick) begin
				fl_cnt_reg <= (fl_cnt_reg == `DPS_FLASH_MS - 8'h1) ? 8'h0 : fl_cnt_reg + 8'h1;
				if (fl_cnt_reg == `DPS_FLASH_MS - 8'h1)
					flash_reg <= ~flash_reg;
				lamp_cnt_reg <= (lamp_cnt_reg == `DPS_LAMP_MS - 8'h1) ? 8'h0 : lamp_cnt_reg + 8'h1;
				if (lamp_cnt_reg == `DPS_LAMP_MS - 8'h1)
					lamp_idx_reg <= (lamp_idx_reg == 3'h4) ? 3'h0 : lamp_idx_reg + 3'h1;
			end
			lamp_flp_lock <= 1'b0;
			lamp_flp_fault <= 1'b0;
			lamp_fix_lock <= 1'b0;
			lamp_fix_fault <= 1'b0;
			lamp_sum_fault <= 1'b0;
			lamp_fix_ready <= 1'b0;
			dig_blank <= !init_reg;
			dig_hi <= 4'h0;
			dig_lo <= 4'h0;
			if (state_reg == S_LAMP) begin
				dig_blank <= 1'b0;
				if (flp_lock_sw || fix_lock_sw) begin
					dig_blank <= ~flash_reg;
					dig_hi <= flp_lock_sw ? 4'h8 : 4'h9;
					dig_lo <= flp_lock_sw ? 4'h8 : 4'h9;
					lamp_flp_lock <= flp_lock_sw;
					lamp_flp_fault <= flp_lock_sw;
					lamp_fix_lock <= fix_lock_sw;
					lamp_fix_fault <= fix_lock_sw;
				end else begin
					lamp_fix_fault <= (lamp_idx_reg == 3'h0);
					lamp_flp_fault <= (lamp_idx_reg == 3'h1);
					lamp_flp_lock <= (lamp_idx_reg == 3'h2);
					lamp_sum_fault <= (lamp_idx_reg == 3'h3);
					lamp_fix_ready <= (lamp_idx_reg == 3'h4);
					dig_hi <= {1'b0, class_sw};
					dig_lo <= {1'b0, mode_sw};
				end
			end else if (state_reg == S_ERR) begin
				dig_blank <= 1'b0;
				dig_hi <= {1'b0, code_reg[8:6]};
				dig_lo <= {1'b0, code_reg[5:3]};
				lamp_sum_fault <= 1'b1;
				lamp_fix_fault <= code_drv_reg;
				lamp_flp_fault <= ~code_drv_reg;
			end else if (state_reg == S_SHOW) begin
				dig_blank <= 1'b0;
				dig_hi <= show_reg[7:4];
				dig_lo <= show_reg[3:0];
			end
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY.
	wire a_take = hsel & htrans[1] & hready;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_ofs_reg <= 4'h0;
			a_wr_reg <= 1'b0;
			a_ok_reg <= 1'b0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			init_reg <= 1'b0;
			halt_reg <= 1'b0;
		end else begin
			halt_reg <= 1'b0;
			a_wr_reg <= a_take & hwrite;
			a_ofs_reg <= haddr[5:2];
			a_ok_reg <= haddr[31:4] == 28'h0 && haddr[1:0] == 2'h0;
			if (a_wr_reg && a_ok_reg && a_ofs_reg == `DPS_OFS_CTRL >> 2) begin
				init_reg <= hwdata[`DPS_CTRL_INIT_BIT];
				halt_reg <= hwdata[`DPS_CTRL_HALT_BIT];
			end
			if (a_take && !hwrite) begin
				case (haddr[31:0])
				{24'h0, `DPS_OFS_CTRL}: hrdata <= {31'h0, init_reg};
				{24'h0, `DPS_OFS_STATUS}: hrdata <= {7'h0, code_reg, 11'h0,
					wen_reg, 1'b0, state_reg};
				{24'h0, `DPS_OFS_CRC}: hrdata <= {27'h0, crc_reg};
				{24'h0, `DPS_OFS_DISP}: hrdata <= {23'h0, dig_blank, dig_hi, dig_lo};
				default: hrdata <= 32'h0;
				endcase
			end
		end
	end
endmodule // dps_sequencer
`default_nettype wire

// *** tb/dps_drive_model.sv ***
// Behavioural drive engine that answers the sequencer's operation requests.
`timescale 1ns/1ps
`default_nettype none
module dps_drive_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic op_req,
	input wire logic [9:0] op_track,
	input wire logic [7:0] lat,
	input wire logic [8:0] err_code,
	input wire logic [9:0] hdr_ofs,
	output logic op_done,
	output logic [8:0] op_err,
	output logic [9:0] op_hdr_trk
);
	logic busy;
	logic [7:0] cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			op_done <= 1'b0;
			op_err <= 9'h000;
			op_hdr_trk <= 10'h000;
		end else begin
			op_done <= 1'b0;
			// Result lines are only valid with op_done, so they toggle otherwise.
			op_err <= ~op_err;
			op_hdr_trk <= ~op_hdr_trk;
			if (op_req) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else if (busy) begin
				busy <= 1'b0;
				op_done <= 1'b1;
				op_err <= err_code;
				// A nonzero offset models a head that settled on the wrong track.
				op_hdr_trk <= op_track ^ hdr_ofs;
			end
		end
	end
endmodule // dps_drive_model
`default_nettype wire

// *** tb/dps_seq_asserts.sv ***
// Port checker for the diagnostic panel sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "dps_map.vh"
module dps_seq_asserts #(
	parameter [9:0] FLP_MAX_TRK = 10'h04c
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire [2:0] mode_sw,
	input wire [2:0] class_sw,
	input wire exec_btn,
	input wire op_req,
	input wire [3:0] op_code,
	input wire op_drive,
	input wire [9:0] op_track,
	input wire op_done,
	input wire dig_blank
);
	reg wr_reg, init_reg, wen_reg, ex_reg;
	reg [3:0] last_reg;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			init_reg <= 1'b0;
			wen_reg <= 1'b0;
			ex_reg <= 1'b0;
			last_reg <= 4'h0;
		end else begin
			wr_reg <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == `DPS_OFS_CTRL;
			if (wr_reg && hwdata[0])
				init_reg <= 1'b1;
			ex_reg <= exec_btn;
			if (exec_btn && !ex_reg && mode_sw == 3'h5 && class_sw == 3'h7)
				wen_reg <= 1'b1;
			else if (mode_sw != 3'h5)
				wen_reg <= 1'b0;
			if (op_req)
				last_reg <= op_code;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low");
	property p_pulse; op_req |=> !op_req; endproperty
	a_pulse: assert property (p_pulse) else $error("op_req longer than one cycle");
	property p_gap; op_done |=> !op_req; endproperty
	a_gap: assert property (p_gap) else $error("op_req right after op_done");
	property p_trk; op_req && op_code == `DPS_OP_SEEK && !op_drive |-> op_track <= FLP_MAX_TRK; endproperty
	a_trk: assert property (p_trk) else $error("floppy seek beyond last track");
	property p_wen; op_req && op_code == `DPS_OP_SEQWR && op_drive |-> wen_reg; endproperty
	a_wen: assert property (p_wen) else $error("fixed write without enable");
	property p_order;
		op_req && mode_sw == 3'h3 && class_sw == 3'h1 && op_code == `DPS_OP_RAM
			|-> last_reg == `DPS_OP_ALU || last_reg == `DPS_OP_RAM;
	endproperty
	a_order: assert property (p_order) else $error("controller test out of order");
	property p_blank; !init_reg |-> dig_blank; endproperty
	a_blank: assert property (p_blank) else $error("digits lit before init");
	property p_scan; op_req && mode_sw == 3'h5 && class_sw == 3'h0 |-> op_code != `DPS_OP_SEQWR; endproperty
	a_scan: assert property (p_scan) else $error("scan wrote the disk");
endmodule // dps_seq_asserts
bind dps_sequencer dps_seq_asserts #(.FLP_MAX_TRK(FLP_MAX_TRK)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .mode_sw(mode_sw),
	.class_sw(class_sw), .exec_btn(exec_btn), .op_req(op_req), .op_code(op_code),
	.op_drive(op_drive), .op_track(op_track), .op_done(op_done), .dig_blank(dig_blank));
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench of the diagnostic panel sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "dps_map.vh"
module tb;
	localparam int MS = 10;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, exec_btn = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] mode_sw = 3'h0, class_sw = 3'h0;
	logic flp_lock_sw = 1'b0, fix_lock_sw = 1'b0, err_drive = 1'b0, norm_err = 1'b0;
	logic [2:0] init_p = 3'h0;
	logic [8:0] norm_err_code = 9'h000, m_err = 9'h000, op_err;
	logic [7:0] lat = 8'h04, dig;
	logic hreadyout, hresp, op_done, op_req, op_drive, op_abort, dig_blank, ab;
	logic [9:0] op_hdr_trk, op_track, hdr_ofs = 10'h000;
	logic [3:0] op_code, dig_hi, dig_lo;
	logic l_fl, l_ff, l_xl, l_xf, l_sf, l_xr;
	logic [14:0] opq[$];
	time tq[$];
	int fail_count = 0, checks_done = 0, cycles = 0;
	assign dig = {dig_hi, dig_lo};
	always #20 hclk = ~hclk;
	dps_sequencer #(.CYC_PER_MS(MS)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mode_sw(mode_sw), .class_sw(class_sw), .exec_btn(exec_btn), .flp_lock_sw(flp_lock_sw),
		.fix_lock_sw(fix_lock_sw), .init_home_fail(init_p[0]), .init_no_drive(init_p[1]),
		.init_trk00_in(init_p[2]), .norm_err(norm_err), .norm_err_code(norm_err_code),
		.err_drive(err_drive), .op_done(op_done), .op_err(op_err), .op_hdr_trk(op_hdr_trk),
		.op_req(op_req), .op_code(op_code), .op_drive(op_drive), .op_track(op_track),
		.op_abort(op_abort), .dig_hi(dig_hi), .dig_lo(dig_lo), .dig_blank(dig_blank),
		.lamp_flp_lock(l_fl), .lamp_flp_fault(l_ff), .lamp_fix_lock(l_xl),
		.lamp_fix_fault(l_xf), .lamp_sum_fault(l_sf), .lamp_fix_ready(l_xr));
	dps_drive_model u_drv (.hclk(hclk), .hresetn(hresetn), .op_req(op_req), .op_track(op_track),
		.lat(lat), .err_code(m_err), .hdr_ofs(hdr_ofs), .op_done(op_done), .op_err(op_err),
		.op_hdr_trk(op_hdr_trk));
	always @(posedge hclk) begin
		cycles++;
		if (op_req) begin
			opq.push_back({op_drive, op_code, op_track});
			tq.push_back($time);
		end
		if (op_abort === 1'b1)
			ab = 1'b1;
		if (cycles == 80000) begin
			fail_count++;
			$display("ERROR t=%0t timeout at %h %h", $time, cycles, 0);
			conclude();
		end
	end
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus transfer: address phase, then data phase; read data taken at its closing edge.
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic press(input logic [2:0] m, input logic [2:0] c);
		mode_sw <= m;
		class_sw <= c;
		repeat (2) @(posedge hclk);
		exec_btn <= 1'b1;
		repeat (3) @(posedge hclk);
		exec_btn <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	// Halting through the control register leaves the init bit set.
	task automatic halt;
		logic [31:0] r;
		ahb(`DPS_OFS_CTRL, 1'b1, 32'h3, r);
		repeat (4) @(posedge hclk);
		opq.delete();
		tq.delete();
	endtask
	task automatic waitq(input int n);
		while (opq.size() < n) @(posedge hclk);
	endtask
	task automatic gap(input int i, input int ms);
		longint g;
		g = (tq[i + 1] - tq[i]) / 40;
		chk(g >= ms * MS - MS && g <= ms * MS + MS + 16, 1);
	endtask
	task automatic t_init;
		logic [31:0] r;
		chk(dig_blank, 1);
		ahb(`DPS_OFS_CTRL, 1'b1, 32'h1, r);
		repeat (3) @(posedge hclk);
		chk({dig_blank, dig}, 0);
		for (int i = 0; i < 3; i++) begin
			err_drive <= i[0];
			init_p <= 3'h1 << i;
			@(posedge hclk);
			init_p <= 3'h0;
			repeat (3) @(posedge hclk);
			chk(dig, i + 1);
			chk({l_sf, l_xf, l_ff}, {1'b1, i[0], ~i[0]});
		end
		norm_err_code <= `DPS_ERR_WPROT;
		norm_err <= 1'b1;
		@(posedge hclk);
		norm_err <= 1'b0;
		repeat (3) @(posedge hclk);
		chk(dig, 8'h10);
		$display("t_init done");
	endtask
	task automatic t_lamp;
		int hit, multi, n;
		logic [4:0] seen, v;
		press(3'h3, 3'h0);
		for (int k = 0; k < 3; k++) begin
			{fix_lock_sw, flp_lock_sw} <= (k == 2) ? 2'b00 : 2'b01 << k;
			repeat (4) @(posedge hclk);
			hit = 0;
			multi = 0;
			seen = 5'h0;
			n = (k == 2) ? 1400 * MS : 600 * MS;
			repeat (n) begin
				@(posedge hclk);
				v = {l_xf, l_ff, l_fl, l_sf, l_xr};
				seen = seen | v;
				multi += ($countones(v) > 1);
				hit += ({dig_blank, dig} === {1'b0, (k == 2) ? 8'h03 : (k ? 8'h99 : 8'h88)});
			end
			if (k == 2) begin
				chk(seen, 5'h1f);
				chk(multi, 0);
				chk(hit, n);
			end else begin
				chk(hit > 0 && hit < n, 1);
				chk({l_fl, l_ff, l_xl, l_xf}, k ? 4'h3 : 4'hc);
			end
		end
		halt();
		$display("t_lamp done");
	endtask
	task automatic t_ctrl;
		press(3'h3, 3'h1);
		waitq(4);
		for (int i = 0; i < 4; i++)
			chk(opq[i][13:10], i);
		for (int c = 2; c < 7; c++) begin
			halt();
			press(3'h3, c[2:0]);
			repeat (60) @(posedge hclk);
			chk(opq.size(), c < 6);
			if (c < 6)
				chk(opq[0][13:10], c - 2);
			else
				chk(dig, 8'h12);
		end
		$display("t_ctrl done");
	endtask
	task automatic t_align;
		logic [9:0] trk[4] = '{10'h001, 10'h002, `DPS_TRK_38, `DPS_TRK_76};
		for (int c = 1; c < 5; c++) begin
			halt();
			press(3'h4, c[2:0]);
			waitq(2);
			chk(opq[0], {1'b0, `DPS_OP_SEEK, trk[c - 1]});
			chk(opq[1][13:10], `DPS_OP_LOAD);
		end
		halt();
		press(3'h4, 3'h0);
		waitq(4);
		chk(opq[0][13:10], `DPS_OP_LOAD);
		chk({opq[1][13:1], opq[2][13:1]}, {`DPS_OP_SEEK, 9'h0, `DPS_OP_SEEK, 9'h0});
		chk(opq[1][0] ^ opq[2][0], 1);
		gap(2, 100);
		ab = 1'b0;
		press(3'h4, 3'h0);
		opq.delete();
		repeat (300 * MS) @(posedge hclk);
		chk({ab, 31'(opq.size())}, {1'b1, 31'h0});
		halt();
		press(3'h4, 3'h5);
		waitq(4);
		chk(opq[0], {1'b0, `DPS_OP_SEEK, 10'h000});
		chk({opq[1][13:10], opq[2][13:10]}, {`DPS_OP_LOAD, `DPS_OP_UNLOAD});
		gap(1, 100);
		gap(2, 200);
		$display("t_align done");
	endtask
	task automatic t_err;
		logic [31:0] r;
		halt();
		m_err <= `DPS_ERR_HDRCRC;
		press(3'h5, 3'h4);
		waitq(16);
		repeat (300) @(posedge hclk);
		ahb(`DPS_OFS_CRC, 1'b0, 32'h0, r);
		chk({opq.size(), r[4:0], hresp}, {32'h10, 5'h10, 1'b0});
		chk({dig, l_sf, l_xf}, {8'h14, 2'b11});
		m_err <= 9'h078;
		press(3'h5, 3'h0);
		repeat (300) @(posedge hclk);
		chk({opq.size(), dig, l_ff}, {32'h11, 8'h17, 1'b1});
		m_err <= `DPS_ERR_NONE;
		halt();
		press(3'h5, 3'h6);
		repeat (40) @(posedge hclk);
		chk({opq.size(), dig}, {32'h0, 8'h10});
		press(3'h5, 3'h7);
		press(3'h5, 3'h6);
		waitq(1);
		chk(opq[0][14:10], {1'b1, `DPS_OP_SEQWR});
		halt();
		press(3'h4, 3'h1);
		halt();
		press(3'h5, 3'h6);
		repeat (40) @(posedge hclk);
		chk({opq.size(), dig}, {32'h0, 8'h10});
		$display("t_err done");
	endtask
	task automatic t_bfly;
		halt();
		press(3'h5, 3'h1);
		waitq(78);
		chk({opq[1][9:0], opq[76][9:0]}, {`DPS_TRK_76, `DPS_TRK_38});
		chk(opq[77], {1'b0, `DPS_OP_SEEK, 10'h000});
		halt();
		press(3'h5, 3'h5);
		waitq(308);
		chk({opq[306], dig}, {1'b1, `DPS_OP_RDHDR, 10'h000, 8'h00});
		halt();
		hdr_ofs <= 10'h001;
		press(3'h5, 3'h2);
		repeat (40) @(posedge hclk);
		chk({opq.size(), dig, l_ff}, {32'h1, 8'h15, 1'b1});
		press(3'h3, 3'h7);
		chk(dig, 8'h42);
		$display("t_bfly done");
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_init();
		t_lamp();
		t_ctrl();
		t_align();
		t_err();
		t_bfly();
		conclude();
	end
endmodule // tb
`default_nettype wire
